// *** verilog/gpio_pkg.sv ***
package gpio_pkg;

  localparam int          PORT_W           = 8;
  localparam logic [15:0] ADDR_INPUT_PINS  = 16'hFFBE;
  // Only the shared address is fixed; the rest sit close to it
  localparam logic [15:0] ADDR_BIDIR_DIR   = 16'hFFB0;
  localparam logic [15:0] ADDR_BIDIR_LATCH = 16'hFFB4;
  localparam logic [15:0] ADDR_PULLUP_EN   = 16'hFFB8;
  localparam logic [15:0] ADDR_TIMER_CTRL  = 16'hFFC0;
  localparam logic [15:0] ADDR_STANDBY     = 16'hFFC4;

  localparam logic [7:0]  RST_DIR          = 8'h00;
  localparam logic [7:0]  RST_LATCH        = 8'h00;
  localparam logic [7:0]  RST_PULLUP       = 8'h00;
  localparam logic [7:0]  RST_OTHER_DIR    = 8'h00;
  localparam logic [7:0]  RST_TIMER_CTRL   = 8'h00;
  localparam logic [1:0]  RST_STANDBY      = 2'h0;

  // Timer control bit positions
  localparam int          TC_CMP_A_OE_BIT  = 0;
  localparam int          TC_CKS_LO_BIT    = 1;
  localparam int          TC_CKS_HI_BIT    = 2;
  localparam logic [1:0]  CKS_EXTERNAL     = 2'h3;
  // Standby control bit positions
  localparam int          SB_HW_BIT        = 0;
  localparam int          SB_SW_BIT        = 1;

  localparam int          PIN_COMPARE_A    = 1;
  localparam int          PIN_EXT_CLOCK    = 0;
  localparam int          PIN_CAPTURE_A    = 2;
  localparam int          PIN_CAPTURE_B    = 3;
  localparam int          KEY_SENSE_W      = 4;

  localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;

  typedef enum logic [1:0] {
    BUS_IDLE  = 2'h0,
    BUS_WRITE = 2'h1,
    BUS_READ  = 2'h2
  } bus_state_t;

  function automatic logic [PORT_W-1:0] read_mix(
    input logic [PORT_W-1:0] dir,
    input logic [PORT_W-1:0] latch,
    input logic [PORT_W-1:0] pins
  );
    read_mix = (dir & latch) | (~dir & pins);
  endfunction

endpackage

// *** verilog/pin_mux.sv ***
`timescale 1ns/1ns
module pin_mux
  import gpio_pkg::*;
#(
  parameter int W = PORT_W
)(
  input  wire logic [W-1:0] dir_bits,
  input  wire logic [W-1:0] latch_bits,
  input  wire logic [W-1:0] pullup_bits,
  input  wire logic         cmp_a_oe,
  input  wire logic         compare_a,
  input  wire logic [1:0]   clk_select,
  input  wire logic         force_off,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe,
  output logic      [W-1:0] pullup_on,
  output logic              ext_clock,
  output logic      [W-1:0] port_read
);

  always_comb
  begin
    pin_out = latch_bits;
    pin_oe  = dir_bits;
    if (cmp_a_oe)
    begin
      pin_out[PIN_COMPARE_A] = compare_a;
      pin_oe[PIN_COMPARE_A]  = 1'b1;
    end
  end

  // Off during reset or hardware standby, whatever the registers hold
  assign pullup_on = force_off ? '0
                   : (pullup_bits & ~dir_bits);

  // Gated so a stray pin edge never clocks the timer
  assign ext_clock = (clk_select == CKS_EXTERNAL)
                   & pin_in[PIN_EXT_CLOCK];

  assign port_read = read_mix(dir_bits, latch_bits, pin_in);

endmodule

// *** verilog/port6_pullup_port7_input.sv ***
// Contract
// - Direction bit picks input or output
// - Pull-up on when enabled and input; the compare pin keeps it on while the timer drives it
// - Reset, hardware standby clear pull-up enables
// - Software standby retains pull-up settings
// - Pull-ups off during reset or hardware standby
// - Second port input only, no direction
// - Second port pins sampled, analog shared
// - Input register read returns pin levels
// - Write there updates other port direction
// - Port read: latch if output, else pin
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ns
module port6_pullup_port7_input
  import gpio_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic [PORT_W-1:0] bidir_pin_in,
  output logic      [PORT_W-1:0] bidir_pin_out,
  output logic      [PORT_W-1:0] bidir_pin_oe,
  output logic      [PORT_W-1:0] bidir_pullup_on,
  input  wire logic [PORT_W-1:0] input_port_pins,
  input  wire logic              compare_a_output,
  output logic                   timer_external_clock_input,
  output logic                   capture_a_input,
  output logic                   capture_b_input,
  output logic      [3:0]        key_sense_input,
  output logic      [PORT_W-1:0] other_port_direction_register,
  output logic                   hw_standby,
  output logic                   sw_standby
);

  // Register picked by one bus address
  typedef enum logic [2:0] {
    SEL_NONE    = 3'h0,
    SEL_DIR     = 3'h1,
    SEL_LATCH   = 3'h2,
    SEL_PULLUP  = 3'h3,
    SEL_SHARED  = 3'h4,
    SEL_TIMER   = 3'h5,
    SEL_STANDBY = 3'h6
  } reg_sel_t;

  // Port side registers
  logic [PORT_W-1:0] dir_q, dir_d;
  logic [PORT_W-1:0] latch_q, latch_d;
  logic [PORT_W-1:0] pullup_q, pullup_d;
  logic [PORT_W-1:0] other_dir_q, other_dir_d;
  logic [7:0]        tctrl_q, tctrl_d;
  logic [1:0]        stby_q, stby_d;
  // Bus side state
  logic [31:0]       rdata_q, rdata_d;
  bus_state_t        st_q, st_d;
  reg_sel_t          sel_q, sel_d;
  reg_sel_t          addr_sel;
  logic [PORT_W-1:0] port_read;
  logic              hw_stby;
  logic              take;
  logic              wr_now;

  // Only the low half of the address is decoded; the rest aliases
  function automatic reg_sel_t decode_reg(input logic [15:0] addr);
    case (addr)
      ADDR_BIDIR_DIR:   decode_reg = SEL_DIR;
      ADDR_BIDIR_LATCH: decode_reg = SEL_LATCH;
      ADDR_PULLUP_EN:   decode_reg = SEL_PULLUP;
      ADDR_INPUT_PINS:  decode_reg = SEL_SHARED;
      ADDR_TIMER_CTRL:  decode_reg = SEL_TIMER;
      ADDR_STANDBY:     decode_reg = SEL_STANDBY;
      default:          decode_reg = SEL_NONE;
    endcase
  endfunction

  assign hw_stby  = stby_q[SB_HW_BIT];
  assign take     = hsel & hready & (htrans == HTRANS_NONSEQ);
  assign addr_sel = decode_reg(haddr[15:0]);
  assign wr_now   = (st_q == BUS_WRITE);

  // Address phase kept for the one data phase that follows it
  always_comb
  begin
    st_d  = BUS_IDLE;
    sel_d = sel_q;
    if (take)
    begin
      st_d  = hwrite ? BUS_WRITE : BUS_READ;
      sel_d = addr_sel;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st_q  <= BUS_IDLE;
      sel_q <= SEL_NONE;
    end
    else
    begin
      st_q  <= st_d;
      sel_q <= sel_d;
    end
  end

  // Writes land at the end of the data phase, where hwdata stands
  always_comb
  begin
    dir_d       = dir_q;
    latch_d     = latch_q;
    pullup_d    = pullup_q;
    other_dir_d = other_dir_q;
    tctrl_d     = tctrl_q;
    stby_d      = stby_q;
    if (wr_now)
    begin
      case (sel_q)
        SEL_DIR:     dir_d       = hwdata[PORT_W-1:0];
        SEL_LATCH:   latch_d     = hwdata[PORT_W-1:0];
        SEL_PULLUP:  pullup_d    = hwdata[PORT_W-1:0];
        SEL_SHARED:  other_dir_d = hwdata[PORT_W-1:0];
        SEL_TIMER:   tctrl_d     = hwdata[7:0];
        SEL_STANDBY: stby_d      = hwdata[1:0];
        default:     ;
      endcase
    end
    // Hardware standby clears direction, latch and pull-up like reset; software standby keeps all.
    // The standby register stays writable so software can leave it.
    if (hw_stby)
    begin
      dir_d    = RST_DIR;
      latch_d  = RST_LATCH;
      pullup_d = RST_PULLUP;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      dir_q       <= RST_DIR;
      latch_q     <= RST_LATCH;
      pullup_q    <= RST_PULLUP;
      other_dir_q <= RST_OTHER_DIR;
      tctrl_q     <= RST_TIMER_CTRL;
      stby_q      <= RST_STANDBY;
    end
    else
    begin
      dir_q       <= dir_d;
      latch_q     <= latch_d;
      pullup_q    <= pullup_d;
      other_dir_q <= other_dir_d;
      tctrl_q     <= tctrl_d;
      stby_q      <= stby_d;
    end
  end

  // Read word is taken in the address phase and stands until the next
  // transfer; a read in a write's data phase sees the older value
  always_comb
  begin
    rdata_d = rdata_q;
    if (take)
    begin
      rdata_d = '0;
      case (addr_sel)
        SEL_DIR:     rdata_d[PORT_W-1:0] = dir_q;
        SEL_LATCH:   rdata_d[PORT_W-1:0] = port_read;
        SEL_PULLUP:  rdata_d[PORT_W-1:0] = pullup_q;
        SEL_SHARED:  rdata_d[PORT_W-1:0] = input_port_pins;
        SEL_TIMER:   rdata_d[7:0]        = tctrl_q;
        SEL_STANDBY: rdata_d[1:0]        = stby_q;
        default:     rdata_d             = '0;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      rdata_q <= 32'h00000000;
    else
      rdata_q <= rdata_d;
  end

  pin_mux #(.W(PORT_W)) u_mux (
    .dir_bits    (dir_q),
    .latch_bits  (latch_q),
    .pullup_bits (pullup_q),
    .cmp_a_oe    (tctrl_q[TC_CMP_A_OE_BIT]),
    .compare_a   (compare_a_output),
    .clk_select  ({tctrl_q[TC_CKS_HI_BIT], tctrl_q[TC_CKS_LO_BIT]}),
    .force_off   (sys_rst | hw_stby),
    .pin_in      (bidir_pin_in),
    .pin_out     (bidir_pin_out),
    .pin_oe      (bidir_pin_oe),
    .pullup_on   (bidir_pullup_on),
    .ext_clock   (timer_external_clock_input),
    .port_read   (port_read)
  );

  // Capture and key-sense stay sampled in either direction, so a pin
  // driven by the port still feeds the timer its own output level
  assign capture_a_input = bidir_pin_in[PIN_CAPTURE_A];
  assign capture_b_input = bidir_pin_in[PIN_CAPTURE_B];
  assign key_sense_input = bidir_pin_in[KEY_SENSE_W-1:0];

  // Second port has no drive path at all; analog use is outside
  assign other_port_direction_register = other_dir_q;
  assign hw_standby = hw_stby;
  assign sw_standby = stby_q[SB_SW_BIT];
  assign hrdata     = rdata_q;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;

endmodule

// *** test/pin_env.sv ***
`timescale 1ns/1ns
module pin_env
  import gpio_pkg::*;
(
  input  wire logic [PORT_W-1:0] oe,
  input  wire logic [PORT_W-1:0] out,
  input  wire logic [PORT_W-1:0] pu,
  input  wire logic [PORT_W-1:0] ext,
  input  wire logic [PORT_W-1:0] en,
  output logic      [PORT_W-1:0] pin
);
  // Floating pin shows the inverse of the latch, or high when its pull-up is on
  assign pin = (oe & out) | (~oe & en & ext)
             | (~oe & ~en & (pu | ~out));
endmodule

// *** test/gpio_props.sv ***
`timescale 1ns/1ns
module gpio_props
  import gpio_pkg::*;
(
  input wire logic              mclk,
  input wire logic              sys_rst,
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [31:0]       hwdata,
  input wire logic [31:0]       hrdata,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic [PORT_W-1:0] bidir_pin_in,
  input wire logic [PORT_W-1:0] bidir_pin_oe,
  input wire logic [PORT_W-1:0] bidir_pullup_on,
  input wire logic [PORT_W-1:0] input_port_pins,
  input wire logic              timer_external_clock_input,
  input wire logic              capture_a_input,
  input wire logic [3:0]        key_sense_input,
  input wire logic [PORT_W-1:0] other_port_direction_register,
  input wire logic              hw_standby
);
  logic hit;
  assign hit = hsel && hreadyout && htrans == HTRANS_NONSEQ
               && haddr[15:0] == ADDR_INPUT_PINS;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Compare pin may be timer-driven with its pull-up still selected
  property p_pu; (bidir_pullup_on & bidir_pin_oe & 8'hFD) == '0; endproperty
  a_pu: assert property (p_pu) else $error("pull-up on output");
  property p_hws; hw_standby |-> bidir_pullup_on == '0; endproperty
  a_hws: assert property (p_hws) else $error("pull-up in standby");
  property p_xc; timer_external_clock_input |-> bidir_pin_in[0]; endproperty
  a_xc: assert property (p_xc) else $error("ext clock wrong");
  property p_cap; capture_a_input == bidir_pin_in[2]
    && key_sense_input == bidir_pin_in[3:0]; endproperty
  a_cap: assert property (p_cap) else $error("capture/key wrong");
  property p_rd; hit && !hwrite |=> hrdata == {24'h0, $past(input_port_pins)};
  endproperty
  a_rd: assert property (p_rd) else $error("pin read wrong");
  property p_wr; hit && hwrite |=> ##1
    other_port_direction_register == $past(hwdata[7:0]); endproperty
  a_wr: assert property (p_wr) else $error("shared write wrong");
  property p_ok; hreadyout && !hresp; endproperty
  a_ok: assert property (p_ok) else $error("bus not OKAY");
  property p_rst; $fell(sys_rst) |-> bidir_pullup_on == '0
    && other_port_direction_register == '0; endproperty
  a_rst: assert property (p_rst) else $error("reset values");
endmodule
bind port6_pullup_port7_input gpio_props u_props (.mclk(mclk),
  .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .bidir_pin_in(bidir_pin_in), .bidir_pin_oe(bidir_pin_oe),
  .bidir_pullup_on(bidir_pullup_on), .input_port_pins(input_port_pins),
  .timer_external_clock_input(timer_external_clock_input),
  .capture_a_input(capture_a_input), .key_sense_input(key_sense_input),
  .other_port_direction_register(other_port_direction_register),
  .hw_standby(hw_standby));

// *** test/port6_pullup_port7_input_test.sv ***
`timescale 1ns/1ns
module port6_pullup_port7_input_test
  import gpio_pkg::*;
;
  logic        mclk = 0, sys_rst = 1, hsel = 0, hwrite = 0, cmpa = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, seed = 26976, r;
  logic [1:0]  htrans = '0;
  logic [2:0]  hsize = '0;
  logic        hreadyout, hresp, xclk, capb, hwsb, swsb, rd_ph = 0;
  logic [7:0]  pin, pout, poe, pu, ext = '0, en = 8'hFF, p7 = '0, odir;
  logic [31:0] exp_q[$];
  int          n_mismatch = 0, checked = 0;
  always #50 mclk = ~mclk;
  port6_pullup_port7_input dut (.mclk, .sys_rst, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .bidir_pin_in(pin), .bidir_pin_out(pout), .bidir_pin_oe(poe),
    .bidir_pullup_on(pu), .input_port_pins(p7), .compare_a_output(cmpa),
    .timer_external_clock_input(xclk), .capture_a_input(),
    .capture_b_input(capb), .key_sense_input(),
    .other_port_direction_register(odir), .hw_standby(hwsb),
    .sw_standby(swsb));
  pin_env env (.oe(poe), .out(pout), .pu, .ext, .en, .pin);
  function logic [31:0] rnd;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task stop_test;
    if (n_mismatch == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task rdy;
    int i;
    i = 0;
    @(posedge mclk);
    while (hreadyout !== 1'b1 && i < 50)
    begin
      i++;
      @(posedge mclk);
    end
    if (i >= 50)
    begin
      n_mismatch++;
      stop_test;
    end
  endtask
  // Reads note their expected word; the monitor pops it in the data phase
  task bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    if (!w)
      exp_q.push_back(d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {16'h0000, a};
    hsize <= 3'h2;
    rdy;
    htrans <= 2'h0;
    hwdata <= w ? d : rnd();
    rdy;
  endtask
  always @(posedge mclk)
  begin
    if (rd_ph && hreadyout === 1'b1)
      chk(hrdata, exp_q.pop_front());
    if (hreadyout === 1'b1)
      rd_ph = hsel && htrans == HTRANS_NONSEQ && !hwrite;
  end
  initial
  begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    bus(0, ADDR_BIDIR_DIR, '0);
    bus(0, ADDR_PULLUP_EN, '0);
    r = rnd();
    ext <= r[15:8] | 8'h01;
    p7 <= r[23:16];
    cmpa <= r[24];
    bus(1, ADDR_BIDIR_DIR, 32'h0C);
    bus(1, ADDR_BIDIR_LATCH, r);
    bus(1, ADDR_PULLUP_EN, 32'hFF);
    bus(0, ADDR_BIDIR_LATCH, (r & 32'h0C) | (ext & 8'hF3));
    #1 chk(pu, 8'hF3);
    chk(capb, r[3]);
    en <= 8'h00;
    bus(0, ADDR_BIDIR_LATCH, (r & 32'h0C) | 32'hF3);
    en <= 8'hFF;
    for (int k = 0; k < 8; k++)
    begin
      bus(1, ADDR_TIMER_CTRL, k);
      #1 chk(xclk, k[2:1] == CKS_EXTERNAL);
      chk(poe[1], k[0]);
      if (k[0])
        chk(pout[1], cmpa);
    end
    bus(0, ADDR_INPUT_PINS, r[23:16]);
    bus(1, ADDR_INPUT_PINS, r[31:24]);
    #1 chk(odir, r[31:24]);
    p7 <= ~r[23:16];
    bus(0, ADDR_INPUT_PINS, {24'h0, ~r[23:16]});
    bus(0, 16'hFFA0, '0);
    bus(1, ADDR_STANDBY, 32'h2);
    #1 chk(pu, 8'hF3);
    chk({hwsb, swsb}, 2'b01);
    bus(1, ADDR_STANDBY, 32'h1);
    #1 chk(pu, 8'h00);
    chk({hwsb, swsb}, 2'b10);
    bus(1, ADDR_STANDBY, 32'h0);
    bus(0, ADDR_PULLUP_EN, '0);
    bus(1, ADDR_PULLUP_EN, 32'hFF);
    #1 chk(pu, 8'hFF);
    // Reset in mid-run with pull-ups on: forced off at once, then cleared
    @(posedge mclk);
    sys_rst <= 1'b1;
    #1 chk(pu, 8'h00);
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    bus(0, ADDR_PULLUP_EN, '0);
    repeat (2) @(posedge mclk);
    stop_test;
  end
endmodule
